// ==== src/sba_defines.svh ====
// sba_defines.svh: offsets, field positions, reset values and timing counts of the secondary arbiter block
// assumes: included by its bare name from the package and the design module
`ifndef SBA_DEFINES_SVH
`define SBA_DEFINES_SVH

// register byte offsets on the avalon word bus
`define SBA_CTRL_OFS 4'h0
`define SBA_STATUS_OFS 4'h4
`define SBA_IRQ_STATUS_OFS 4'h8
`define SBA_IRQ_MASK_OFS 4'hc

// control register fields
`define SBA_CTRL_SEC_RESET_BIT 0
`define SBA_CTRL_BRIDGE_REQ_BIT 1
`define SBA_CTRL_ASYNC_MODE_BIT 2
`define SBA_CTRL_RESET_VAL 32'h0000_0001

// status register fields
`define SBA_ST_GRANT_LSB 0
`define SBA_ST_OWNER_LSB 16
`define SBA_ST_FAST_BIT 20
`define SBA_ST_EXT_ARB_BIT 21
`define SBA_ST_SEC_RESET_BIT 22
`define SBA_ST_SERR_BIT 23
`define SBA_ST_BRIDGE_GNT_BIT 24

// interrupt event bits
`define SBA_EV_SERR_BIT 0
`define SBA_EV_ABORT_BIT 1
`define SBA_EV_BRIDGE_GNT_BIT 2
`define SBA_EV_WIDTH 3
`define SBA_IRQ_RESET_VAL 3'h0

// grant turnaround: cycles of the gap state, in which every grant line stays high, before the arbiter returns to idle
`define SBA_GNT_GAP_CYCLES 2
// cycles after frame assertion within which a target must claim
`define SBA_DEVSEL_WAIT_CYCLES 5

`endif

// ==== src/sba_pkg.sv ====
// sba_pkg.sv: types shared by the secondary arbiter block
// assumes: sba_defines.svh supplies the numeric constants
package sba_pkg;
    `include "sba_defines.svh"

    typedef enum logic [1:0] {
        SBA_IDLE,
        SBA_GRANTED,
        SBA_GAP
    } sba_arb_state_e;

    typedef enum logic [1:0] {
        SBA_M_IDLE,
        SBA_M_WAIT_CLAIM,
        SBA_M_DATA
    } sba_mst_state_e;
endpackage

// ==== src/sba_arbiter.sv ====
// sba_arbiter.sv: secondary-side arbiter, parking, secondary reset, fast-clock indication and error reporting
// assumes: clk is the secondary bus clock, every input synchronous to it, avalon-mm slave for registers
`timescale 1ns/1ps
`include "sba_defines.svh"

module sba_arbiter
    import sba_pkg::*;
#(
    parameter int NREQ = 9,
    parameter int AD_WIDTH = 32,
    parameter int CBE_WIDTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq,
    input wire logic [NREQ-1:0] sec_req_n,
    output logic [NREQ-1:0] sec_gnt_n_o,
    output logic [NREQ-1:0] sec_gnt_n_oe,
    input wire logic sec_frame_n,
    input wire logic sec_irdy_n,
    input wire logic sec_devsel_n,
    output logic [AD_WIDTH-1:0] sec_ad_o,
    output logic sec_ad_oe,
    output logic [CBE_WIDTH-1:0] sec_cmd_byte_enable_o,
    output logic sec_cmd_byte_enable_oe,
    output logic sec_parity_o,
    output logic sec_parity_oe,
    output logic sec_ctrl_oe,
    input wire logic pri_reset_n,
    output logic sec_reset_n,
    input wire logic pri_fast_clock_enable,
    input wire logic sec_fast_clock_enable_i,
    output logic sec_fast_clock_enable_o,
    output logic sec_fast_clock_enable_oe,
    output logic sec_fast_mode,
    input wire logic sec_central_function_strap_n,
    input wire logic sec_system_error_n,
    input wire logic bridge_frame_start,
    output logic bridge_master_abort
);
    localparam int NAG = NREQ + 1; // slot NREQ is the bridge itself
    localparam int IW = $clog2(NAG);

    // ---------------- register file ----------------
    logic [31:0] ctrl, next_ctrl;
    logic [`SBA_EV_WIDTH-1:0] irq_status, next_irq_status;
    logic [`SBA_EV_WIDTH-1:0] irq_mask, next_irq_mask;
    logic [31:0] next_readdata;
    logic rd_pending, next_rd_pending;
    logic [`SBA_EV_WIDTH-1:0] events;
    logic [31:0] status_word;

    // strap bit sampled once after reset release
    logic strap_ext, next_strap_ext;
    logic strap_taken, next_strap_taken;

    // ---------------- arbiter state ----------------
    sba_arb_state_e arb_state, next_arb_state;
    logic [IW-1:0] owner, next_owner;
    logic [IW-1:0] last, next_last;
    logic [1:0] gap_cnt, next_gap_cnt;
    logic frame_prev, next_frame_prev;
    logic bus_busy;
    logic [NAG-1:0] pending;
    logic found;
    logic [IW-1:0] pick;
    logic [NREQ-1:0] gnt_vec;
    logic bridge_gnt;

    // ---------------- master claim watch ----------------
    sba_mst_state_e mst_state, next_mst_state;
    logic [2:0] claim_cnt, next_claim_cnt;
    logic abort_pulse;

    logic sec_rst_active;
    logic serr_prev, next_serr_prev;

    // the bus decides; reset from either source
    assign sec_rst_active = !pri_reset_n || ctrl[`SBA_CTRL_SEC_RESET_BIT];
    assign sec_reset_n = !sec_rst_active;

    // request vector, bridge as the last slot
    genvar gi;
    generate
        for (gi = 0; gi < NREQ; gi++) begin : g_req
            assign pending[gi] = !sec_req_n[gi] && !strap_ext;
        end
    endgenerate
    assign pending[NREQ] = ctrl[`SBA_CTRL_BRIDGE_REQ_BIT] && !strap_ext;
    assign bus_busy = !sec_frame_n || !sec_irdy_n;

    // rotating priority search starting after the last owner
    always_comb begin
        int k;
        int idx;
        k = 0;
        idx = 0;
        found = 1'b0;
        pick = last;
        for (k = 1; k <= NAG; k++) begin
            idx = (int'(last) + k) % NAG;
            if (!found && pending[idx]) begin
                found = 1'b1;
                pick = IW'(idx);
            end
        end
    end

    always_comb begin
        next_arb_state = arb_state;
        next_owner = owner;
        next_last = last;
        next_gap_cnt = gap_cnt;
        next_frame_prev = sec_frame_n;
        case (arb_state)
            SBA_IDLE: begin
                // park on the bridge unless a request can be granted on an idle bus
                next_owner = IW'(NREQ);
                if (found && !bus_busy) begin
                    next_owner = pick;
                    next_last = pick;
                    next_arb_state = SBA_GRANTED;
                end
            end
            SBA_GRANTED: begin
                // release once the owner started (frame fell) or, unless it is the bridge, dropped its request while bus idle
                if ((frame_prev && !sec_frame_n) || (!pending[owner] && !bus_busy && owner != IW'(NREQ))) begin
                    next_arb_state = SBA_GAP;
                    next_gap_cnt = 2'(`SBA_GNT_GAP_CYCLES);
                end
            end
            SBA_GAP: begin
                next_gap_cnt = gap_cnt - 2'd1;
                if (gap_cnt == 2'd1) begin
                    next_arb_state = SBA_IDLE;
                end
            end
            default: next_arb_state = SBA_IDLE;
        endcase
        // a grant cut by reset or strap still serves its full turnaround gap
        if (sec_rst_active || strap_ext) begin
            if (arb_state == SBA_GRANTED) begin
                next_arb_state = SBA_GAP;
                next_gap_cnt = 2'(`SBA_GNT_GAP_CYCLES);
            end else if (arb_state != SBA_GAP) begin
                next_arb_state = SBA_IDLE;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            arb_state <= SBA_IDLE;
            owner <= IW'(NREQ);
            last <= IW'(NREQ);
            gap_cnt <= 2'h0;
            frame_prev <= 1'b1;
        end else begin
            arb_state <= next_arb_state;
            owner <= next_owner;
            last <= next_last;
            gap_cnt <= next_gap_cnt;
            frame_prev <= next_frame_prev;
        end
    end

    // only one grant, and none during the turnaround gap
    generate
        for (gi = 0; gi < NREQ; gi++) begin : g_gnt
            assign gnt_vec[gi] = (arb_state == SBA_GRANTED) && (owner == IW'(gi));
        end
    endgenerate

    // in external mode grant line 0 carries the bridge request, request line 0 its grant
    assign bridge_gnt = strap_ext ? !sec_req_n[0] : (arb_state != SBA_GAP && owner == IW'(NREQ));
    always_comb begin
        sec_gnt_n_o = ~gnt_vec;
        sec_gnt_n_oe = {NREQ{!sec_rst_active}};
        if (strap_ext) begin
            sec_gnt_n_o = {NREQ{1'b1}};
            sec_gnt_n_o[0] = !ctrl[`SBA_CTRL_BRIDGE_REQ_BIT];
            sec_gnt_n_oe = {{(NREQ-1){1'b0}}, !sec_rst_active};
        end
    end

    // parking drive and reset zero drive
    always_comb begin
        sec_ad_o = '0;
        sec_cmd_byte_enable_o = '0;
        sec_parity_o = 1'b0; // even parity of all-zero bus
        sec_ctrl_oe = 1'b0;
        sec_ad_oe = sec_rst_active || (bridge_gnt && !bus_busy);
        sec_cmd_byte_enable_oe = sec_ad_oe;
        sec_parity_oe = sec_ad_oe;
    end

    // fast clock indication; open drain only driven low
    always_comb begin
        sec_fast_clock_enable_o = 1'b0;
        sec_fast_clock_enable_oe = !ctrl[`SBA_CTRL_ASYNC_MODE_BIT] && !pri_fast_clock_enable;
        if (ctrl[`SBA_CTRL_ASYNC_MODE_BIT]) begin
            sec_fast_mode = sec_fast_clock_enable_i;
        end else begin
            sec_fast_mode = sec_fast_clock_enable_i && pri_fast_clock_enable;
        end
    end

    // claim watch for bridge-mastered transfers
    always_comb begin
        next_mst_state = mst_state;
        next_claim_cnt = claim_cnt;
        abort_pulse = 1'b0;
        case (mst_state)
            SBA_M_IDLE: begin
                if (bridge_frame_start && bridge_gnt) begin
                    next_mst_state = SBA_M_WAIT_CLAIM;
                    next_claim_cnt = 3'h1;
                end
            end
            SBA_M_WAIT_CLAIM: begin
                if (!sec_devsel_n) begin
                    next_mst_state = SBA_M_DATA;
                end else if (claim_cnt == 3'(`SBA_DEVSEL_WAIT_CYCLES)) begin
                    abort_pulse = 1'b1;
                    next_mst_state = SBA_M_IDLE;
                end else begin
                    next_claim_cnt = claim_cnt + 3'h1;
                end
            end
            SBA_M_DATA: begin
                if (sec_frame_n && sec_irdy_n) begin
                    next_mst_state = SBA_M_IDLE;
                end
            end
            default: next_mst_state = SBA_M_IDLE;
        endcase
        if (sec_rst_active) begin
            next_mst_state = SBA_M_IDLE;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mst_state <= SBA_M_IDLE;
            claim_cnt <= 3'h0;
            bridge_master_abort <= 1'b0;
        end else begin
            mst_state <= next_mst_state;
            claim_cnt <= next_claim_cnt;
            bridge_master_abort <= abort_pulse;
        end
    end

    // events: system error falling edge, master abort, bridge grant received
    assign events[`SBA_EV_SERR_BIT] = serr_prev && !sec_system_error_n;
    assign events[`SBA_EV_ABORT_BIT] = abort_pulse;
    assign events[`SBA_EV_BRIDGE_GNT_BIT] = strap_ext && ctrl[`SBA_CTRL_BRIDGE_REQ_BIT] && !sec_req_n[0];

    always_comb begin
        status_word = '0;
        status_word[`SBA_ST_GRANT_LSB +: NREQ] = gnt_vec;
        status_word[`SBA_ST_OWNER_LSB +: IW] = owner;
        status_word[`SBA_ST_FAST_BIT] = sec_fast_mode;
        status_word[`SBA_ST_EXT_ARB_BIT] = strap_ext;
        status_word[`SBA_ST_SEC_RESET_BIT] = sec_rst_active;
        status_word[`SBA_ST_SERR_BIT] = !sec_system_error_n;
        status_word[`SBA_ST_BRIDGE_GNT_BIT] = bridge_gnt;
    end

    // one wait state on reads so read data come from a flop
    assign avs_waitrequest = avs_read && !rd_pending;

    always_comb begin
        next_ctrl = ctrl;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        next_readdata = avs_readdata;
        next_rd_pending = 1'b0;
        next_serr_prev = sec_system_error_n;
        next_strap_taken = 1'b1;
        next_strap_ext = strap_taken ? strap_ext : sec_central_function_strap_n;
        if (avs_read && !rd_pending) begin
            next_rd_pending = 1'b1;
            case (avs_address)
                `SBA_CTRL_OFS: next_readdata = {29'h0, ctrl[2:0]};
                `SBA_STATUS_OFS: next_readdata = status_word;
                `SBA_IRQ_STATUS_OFS: begin
                    next_readdata = {29'h0, irq_status};
                    next_irq_status = '0; // read clears
                end
                `SBA_IRQ_MASK_OFS: next_readdata = {29'h0, irq_mask};
                default: next_readdata = 32'h0;
            endcase
        end
        if (avs_write && avs_byteenable[0]) begin
            case (avs_address)
                `SBA_CTRL_OFS: next_ctrl = {29'h0, avs_writedata[2:0]};
                `SBA_IRQ_MASK_OFS: next_irq_mask = avs_writedata[`SBA_EV_WIDTH-1:0];
                default: ;
            endcase
        end
        // a new event wins over the read clear
        next_irq_status = next_irq_status | events;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `SBA_CTRL_RESET_VAL;
            irq_status <= `SBA_IRQ_RESET_VAL;
            irq_mask <= `SBA_IRQ_RESET_VAL;
            avs_readdata <= 32'h0;
            rd_pending <= 1'b0;
            serr_prev <= 1'b1;
            strap_ext <= 1'b0;
            strap_taken <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            irq_status <= next_irq_status;
            irq_mask <= next_irq_mask;
            avs_readdata <= next_readdata;
            rd_pending <= next_rd_pending;
            serr_prev <= next_serr_prev;
            strap_ext <= next_strap_ext;
            strap_taken <= next_strap_taken;
        end
    end

    assign irq = |(irq_status & irq_mask);
endmodule

// ==== testbench/sba_arbiter_properties.sv ====
// sba_arbiter_properties.sv: port-level checker for the secondary arbiter
// assumes: bound to sba_arbiter, every signal on clk
`timescale 1ns/1ps
module sba_arbiter_properties #(
    parameter int NREQ = 9,
    parameter int AD_WIDTH = 32,
    parameter int CBE_WIDTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [NREQ-1:0] sec_gnt_n_o,
    input wire logic [NREQ-1:0] sec_gnt_n_oe,
    input wire logic sec_devsel_n,
    input wire logic [AD_WIDTH-1:0] sec_ad_o,
    input wire logic sec_ad_oe,
    input wire logic [CBE_WIDTH-1:0] sec_cmd_byte_enable_o,
    input wire logic sec_cmd_byte_enable_oe,
    input wire logic sec_parity_o,
    input wire logic sec_parity_oe,
    input wire logic sec_ctrl_oe,
    input wire logic pri_reset_n,
    input wire logic sec_reset_n,
    input wire logic pri_fast_clock_enable,
    input wire logic sec_fast_clock_enable_i,
    input wire logic sec_fast_clock_enable_o,
    input wire logic sec_fast_clock_enable_oe,
    input wire logic sec_fast_mode,
    input wire logic sec_central_function_strap_n,
    input wire logic bridge_frame_start,
    input wire logic bridge_master_abort
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_gnt_turnaround: assert property (!sec_central_function_strap_n &&
        |(sec_gnt_n_o & ~$past(sec_gnt_n_o)) |=> &sec_gnt_n_o) else $error("grant fell inside gap");
    a_single_grant: assert property (!sec_central_function_strap_n |->
        $countones(~sec_gnt_n_o & sec_gnt_n_oe) <= 1) else $error("two grants");
    a_pri_reset_follow: assert property (!pri_reset_n |-> !sec_reset_n) else $error("reset not passed");
    a_reset_lines_idle: assert property (!sec_reset_n |-> sec_ad_oe && sec_ad_o == '0 &&
        sec_cmd_byte_enable_oe && sec_cmd_byte_enable_o == '0 && sec_parity_oe && !sec_parity_o &&
        !sec_ctrl_oe && sec_gnt_n_oe == '0) else $error("bad lines in reset");
    a_fast_mode_level: assert property ($stable(sec_fast_clock_enable_i)[*3] |->
        sec_fast_mode == sec_fast_clock_enable_i) else $error("fast mode wrong");
    a_fast_pull_low: assert property (pri_fast_clock_enable && $past(pri_fast_clock_enable) |->
        !sec_fast_clock_enable_oe && !sec_fast_clock_enable_o) else $error("fast line pulled");
    a_claim_abort: assert property (bridge_frame_start ##1 sec_devsel_n[*5] |->
        ##[0:2] bridge_master_abort) else $error("no abort");
    a_claim_no_abort: assert property (bridge_frame_start ##[1:4] !sec_devsel_n |=>
        !bridge_master_abort[*6]) else $error("abort after claim");
endmodule
bind sba_arbiter sba_arbiter_properties #(.NREQ(NREQ), .AD_WIDTH(AD_WIDTH), .CBE_WIDTH(CBE_WIDTH))
    sba_arbiter_properties_i (.*);

// ==== testbench/sba_initiators.sv ====
// sba_initiators.sv: behavioural secondary-bus initiators and a target
// assumes: gnt_n is the resolved grant wire, released lines pulled up
`timescale 1ns/1ps
module sba_initiators (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [8:0] want,
    input wire logic [8:0] gnt_n,
    input wire logic claim,
    input wire logic bridge_frame_start,
    output logic [8:0] req_n,
    output logic frame_n,
    output logic irdy_n,
    output logic devsel_n
);
    logic [2:0] cnt;
    logic [2:0] tcnt;
    assign req_n = ~want;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 3'h0;
            tcnt <= 3'h0;
        end else begin
            // short burst only on an idle bus, so a slow grant is never overrun
            if (cnt != 3'h0) cnt <= cnt - 3'h1;
            else if (|(~gnt_n & want) && frame_n && irdy_n) cnt <= 3'h3;
            if (tcnt != 3'h0) tcnt <= tcnt - 3'h1;
            else if (bridge_frame_start && claim) tcnt <= 3'h3;
        end
    end
    assign frame_n = cnt != 3'h3;
    assign irdy_n = cnt == 3'h0;
    assign devsel_n = !(cnt == 3'h1 || tcnt == 3'h1);
endmodule

// ==== testbench/tb_top.sv ====
// tb_top.sv: self-checking bench for the secondary arbiter
// assumes: sba_initiators stands on the bus, checker attached by bind
`timescale 1ns/1ps
`include "sba_defines.svh"
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest, irq, sec_reset_n, sec_fast_mode, fast_oe, ad_oe, frame_n, irdy_n, devsel_n;
    logic [8:0] gnt_o, gnt_oe, part_req;
    logic [8:0] gprev = 9'h1ff;
    logic [8:0] want = 9'h0;
    logic pri_reset_n = 1'b1;
    logic pri_fast = 1'b1;
    logic fast_pull = 1'b1;
    logic strap = 1'b0;
    logic serr_n = 1'b1;
    logic ext_gnt_n = 1'b1;
    logic claim = 1'b0;
    logic frame_start = 1'b0;
    logic [63:0] exp_q[$];
    logic [63:0] note;
    int errors = 0;
    int cmp_count = 0;
    int seed = 71440;
    int last = -1;
    int grants = 0;
    int idx, e, cyc;
    // grant and fast-clock lines carry pull-ups
    wire logic [8:0] gnt_wire = ~(gnt_oe & ~gnt_o);
    wire logic [8:0] sec_req = strap ? {part_req[8:1], ext_gnt_n} : part_req;
    wire logic fast_wire = fast_pull & ~fast_oe;
    sba_arbiter sba_arbiter_i (.clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .sec_req_n(sec_req),
        .sec_gnt_n_o(gnt_o), .sec_gnt_n_oe(gnt_oe), .sec_frame_n(frame_n), .sec_irdy_n(irdy_n),
        .sec_devsel_n(devsel_n), .sec_ad_o(), .sec_ad_oe(ad_oe), .sec_cmd_byte_enable_o(),
        .sec_cmd_byte_enable_oe(), .sec_parity_o(), .sec_parity_oe(), .sec_ctrl_oe(),
        .pri_reset_n(pri_reset_n), .sec_reset_n(sec_reset_n), .pri_fast_clock_enable(pri_fast),
        .sec_fast_clock_enable_i(fast_wire), .sec_fast_clock_enable_o(), .sec_fast_clock_enable_oe(fast_oe),
        .sec_fast_mode(sec_fast_mode), .sec_central_function_strap_n(strap), .sec_system_error_n(serr_n),
        .bridge_frame_start(frame_start), .bridge_master_abort());
    sba_initiators sba_initiators_i (.clk(clk), .rst_n(rst_n), .want(want), .gnt_n(gnt_wire),
        .claim(claim), .bridge_frame_start(frame_start), .req_n(part_req), .frame_n(frame_n),
        .irdy_n(irdy_n), .devsel_n(devsel_n));
    initial forever #20 clk = ~clk;
    task automatic wrap_up;
        $display("errors %0d compares %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic [31:0] m);
        exp_q.push_back({x, m});
        acc(1'b0, a, 32'h0);
    endtask
    task automatic do_reset(input logic s);
        @(posedge clk);
        rst_n <= 1'b0;
        strap <= s;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc > 20000) begin
            errors++;
            wrap_up();
        end
        if (avs_read && avs_waitrequest === 1'b0) begin
            note = exp_q.pop_front();
            chk(avs_readdata & note[31:0], note[63:32]);
        end
        // a new owner appears only after all lines were high
        if (rst_n && !strap && &gprev && !(&gnt_wire)) begin
            for (int k = 0; k < 9; k++) if (!gnt_wire[k]) idx = k;
            if (last >= 0) begin
                e = last;
                do e = (e + 1) % 9; while (!want[e]);
                chk(32'(idx), 32'(e));
            end
            last = idx;
            grants++;
        end
        gprev = gnt_wire;
    end
    initial begin
        do_reset(1'b0);
        @(negedge clk);
        chk(32'({sec_reset_n, ad_oe}), 32'h1);
        rd(`SBA_CTRL_OFS, `SBA_CTRL_RESET_VAL, 32'h7);
        acc(1'b1, `SBA_CTRL_OFS, 32'h0);
        @(negedge clk);
        chk(32'(sec_reset_n), 32'h1);
        @(posedge clk);
        pri_reset_n <= 1'b0;
        repeat (2) @(negedge clk);
        chk(32'(sec_reset_n), 32'h0);
        @(posedge clk);
        pri_reset_n <= 1'b1;
        for (int m = 0; m < 8; m++) begin
            acc(1'b1, `SBA_CTRL_OFS, {29'h0, m[2], 2'b00});
            pri_fast <= m[1];
            fast_pull <= m[0];
            repeat (4) @(negedge clk);
            chk(32'(fast_oe), 32'(!m[2] && !m[1]));
            chk(32'(sec_fast_mode), 32'(m[0] && (m[2] || m[1])));
        end
        for (int p = 0; p < 4; p++) begin
            @(posedge clk);
            want <= 9'($random(seed)) | 9'(1 << p);
            last = -1;
            repeat (80) @(posedge clk);
        end
        chk(32'(grants > 20), 32'h1);
        want <= 9'h0;
        repeat (8) @(negedge clk);
        chk(32'(ad_oe), 32'h1);
        acc(1'b1, `SBA_CTRL_OFS, 32'h2);
        acc(1'b1, `SBA_IRQ_MASK_OFS, 32'h2);
        rd(`SBA_STATUS_OFS, 32'h0100_0000, 32'h0100_0000);
        for (int c = 0; c < 2; c++) begin
            @(posedge clk);
            claim <= c[0];
            frame_start <= 1'b1;
            serr_n <= !c[0];
            @(posedge clk);
            frame_start <= 1'b0;
            serr_n <= 1'b1;
            repeat (12) @(negedge clk);
            chk(32'(irq), 32'(!c[0]));
            rd(`SBA_IRQ_STATUS_OFS, {30'h0, !c[0], c[0]}, 32'h3);
        end
        do_reset(1'b1);
        acc(1'b1, `SBA_CTRL_OFS, 32'h2);
        repeat (2) @(negedge clk);
        chk(32'({gnt_oe[0], gnt_o[0]}), 32'h2);
        @(posedge clk);
        ext_gnt_n <= 1'b0;
        rd(`SBA_STATUS_OFS, 32'h0120_0000, 32'h0120_0000);
        rd(`SBA_IRQ_STATUS_OFS, 32'h4, 32'h4);
        wrap_up();
    end
endmodule
